// File: src/sit_pkg.sv
// Constants and carrier types for the serial/infrared status and timer banks.
package sit_pkg;

  // Clock and timer tick timing.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_PERIOD_NS = 125000;
  localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PRESC_W = 16;

  // Widths.
  localparam int APB_AW = 8;
  localparam int FILL_W = 6;
  localparam int TIMER_W = 12;
  localparam int TIMER_LO_W = 8;
  localparam int TIMER_HI_W = 4;
  localparam int FRAME_W = 13;
  localparam int FRAME_HI_W = 5;

  // Register indices within a bank; byte address is four times the index.
  localparam logic [2:0] IDX_TIMER_LOW = 3'h0;
  localparam logic [2:0] IDX_TIMER_HIGH = 3'h1;
  localparam logic [2:0] IDX_IR_CONTROL = 3'h2;
  localparam logic [2:0] IDX_LINE_BANK = 3'h3;
  localparam logic [2:0] IDX_TX_LEN_LOW = 3'h4;
  localparam logic [2:0] IDX_TX_LEN_HIGH = 3'h5;
  localparam logic [2:0] IDX_RX_LEN_LOW = 3'h6;
  localparam logic [2:0] IDX_RX_LEN_HIGH = 3'h7;
  localparam logic [2:0] IDX_FIFO_CONTROL = 3'h2;
  localparam logic [2:0] IDX_EXT_CONTROL = 3'h2;
  localparam logic [2:0] IDX_BANK2_RSVD = 3'h5;
  localparam logic [2:0] IDX_TX_FILL = 3'h6;
  localparam logic [2:0] IDX_RX_FILL = 3'h7;
  localparam logic [2:0] IDX_REVISION = 3'h0;
  localparam logic [2:0] IDX_LINE_SHADOW = 3'h1;
  localparam logic [2:0] IDX_FIFO_SHADOW = 3'h2;

  // Bank numbers and bank selector layout.
  localparam logic [2:0] BANK_0 = 3'h0;
  localparam logic [2:0] BANK_2 = 3'h2;
  localparam logic [2:0] BANK_3 = 3'h3;
  localparam logic [2:0] BANK_4 = 3'h4;
  localparam int BANK_SEL_BIT = 7;

  // Field positions.
  localparam int ICR_RUN_BIT = 0;
  localparam int ICR_TEST_BIT = 1;
  localparam int ICR_SEL_LSB = 2;
  localparam int ICR_W = 4;
  localparam int EXT_MODE_BIT = 0;

  // Reset values.
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [FRAME_W-1:0] FRAME_LEN_RST = 13'h0800;

  // Interface selected by the legacy infrared select field.
  typedef enum logic [1:0] {
    SIT_IF_SERIAL = 2'h0,
    SIT_IF_RESERVED = 2'h1,
    SIT_IF_AMPLITUDE_IR = 2'h2,
    SIT_IF_SERIAL_IR = 2'h3
  } sit_if_mode_e;

  // APB request from the master.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata;
  } sit_apb_req_s;

  // APB answer to the master.
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } sit_apb_rsp_s;

  // Whole state of the register bank.
  typedef struct packed {
    sit_apb_rsp_s apb;
    logic [7:0] line_bank;
    logic [7:0] line_control;
    logic [7:0] fifo_control;
    logic [7:0] ext_control;
    logic [ICR_W-1:0] ir_control;
    sit_if_mode_e if_mode;
    logic [TIMER_W-1:0] reload;
    logic [TIMER_W-1:0] count;
    logic [TIMER_HI_W-1:0] high_latch;
    logic [PRESC_W-1:0] presc;
    logic expire;
    logic [FRAME_W-1:0] tx_len;
    logic [FRAME_W-1:0] rx_len;
  } sit_state_s;

  localparam sit_state_s SIT_STATE_RST = '{
    if_mode: SIT_IF_SERIAL,
    tx_len: FRAME_LEN_RST,
    rx_len: FRAME_LEN_RST,
    default: '0
  };

endpackage

// File: src/sit_regs.sv
// Status, shadow and interval timer register banks behind an APB slave.
//
// Function
// - Bank 2 index 5 is reserved: zero after reset, reads zero.
// - Bank 2 index 6 returns transmit FIFO count in bits 5-0.
// - Bank 2 index 7 returns receive FIFO count in bits 5-0.
// - Bank 3 decodes revision, shadows and line/bank; 4-7 are reserved.
// - Revision register: module type upper nibble, revision lower nibble.
// - Line shadow returns line control, set by index 3 writes with bit 7 clear in any bank.
// - FIFO control shadow returns the write-only bank 0 FIFO control.
// - Bank 3 index 3 reaches the same line control and bank selector.
// - Bank 4 decodes timer, infrared control, line/bank, frame lengths.
// - Timer reload is 12 bits: low byte plus four high bits.
// - Down-counter decrements once per 125 us tick.
// - Writing the timer high byte loads the down-counter from reload.
// - Timer reads give live count, or reload when counter test is set.
// - Timer low read latches upper four count bits for the high read.
// - Infrared control one clears on reset; bits 7-4 read zero.
// - Infrared control bit 0 runs the timer; zero freezes the count.
// - Counter test makes reads return reload and programmed lengths.
// - Bits 3-2 pick serial or infrared mode outside extended mode.
// - Extended control bit 0 selects extended mode, overriding legacy.
//
// Register access over APB was left to the implementer.
module sit_regs
  import sit_pkg::*;
#(
  parameter logic [3:0] MODULE_TYPE = 4'h5, // Arbitrary value.
  parameter logic [3:0] REVISION = 4'h1, // Arbitrary value.
  parameter int unsigned TICK_COUNT = TICK_CYCLES
) (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst,
  // APB slave.
  input wire sit_apb_req_s i_apb,
  output sit_apb_rsp_s o_apb,
  // Live levels and counts from the FIFO and frame logic.
  input wire logic [FILL_W-1:0] i_tx_fill_count,
  input wire logic [FILL_W-1:0] i_rx_fill_count,
  input wire logic [FRAME_W-1:0] i_tx_frame_count,
  input wire logic [FRAME_W-1:0] i_rx_frame_count,
  // Control values for the rest of the module.
  output logic [7:0] o_line_control,
  output logic [7:0] o_fifo_control,
  output logic o_extended_mode,
  output sit_if_mode_e o_legacy_infrared_select,
  output logic [FRAME_W-1:0] o_tx_frame_length,
  output logic [FRAME_W-1:0] o_rx_frame_max_length,
  // Interval timer.
  output logic o_timer_expired,
  output logic [TIMER_W-1:0] o_timer_count
);

  // The prescaler wraps after TICK_COUNT clocks; at 100 MHz the default
  // gives one 125 us tick, so a full 4095 reload lasts about half a second.
  // A small TICK_COUNT is only meant for simulation of the timer path.
  localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(TICK_COUNT - 1);
  localparam logic [TIMER_W-1:0] COUNT_ONE = 12'h001;

  // All state lives in one packed struct: st_r is the register and st_nxt
  // its next value, filled by the single combinational process below.
  sit_state_s st_r;
  sit_state_s st_nxt;

  // Current bank from the bank selector. A byte without the select bit set
  // is a plain line control value, so the bus falls back to bank 0 then.
  // Only the low three bits name the bank; banks 1 and 5 to 7 read zero except at index 3.
  function automatic logic [2:0] cur_bank(input logic [7:0] line_bank);
    if (line_bank[BANK_SEL_BIT]) begin
      cur_bank = line_bank[2:0];
    end else begin
      cur_bank = BANK_0;
    end
  endfunction

  // Upper five bits of a frame length or count, zero padded to a byte.
  function automatic logic [7:0] frame_hi(input logic [FRAME_W-1:0] v);
    frame_hi = {3'h0, v[12:8]};
  endfunction

  // Pick between live value and programmed value by the counter test bit.
  // Live counts are read unfrozen; software must take care of tearing.
  function automatic logic [7:0] test_mux(input logic test,
                                           input logic [7:0] live,
                                           input logic [7:0] prog);
    test_mux = test ? prog : live;
  endfunction

  // Read value of one register; reserved locations read zero.
  // Index 3 is shared by every bank and reaches the line/bank selector.
  // Levels are not frozen during the read, so a level that moves while it
  // is sampled can come back torn; software reads it three times.
  function automatic logic [7:0] read_byte(
    input sit_state_s st,
    input logic [2:0] bank,
    input logic [2:0] idx,
    input logic [FILL_W-1:0] tx_fill,
    input logic [FILL_W-1:0] rx_fill,
    input logic [FRAME_W-1:0] tx_cnt,
    input logic [FRAME_W-1:0] rx_cnt
  );
    logic test;
    test = st.ir_control[ICR_TEST_BIT];
    read_byte = BYTE_RST;
    if (idx == IDX_LINE_BANK) begin
      read_byte = st.line_bank;
    end else begin
      unique case (bank)
        BANK_2: begin
          if (idx == IDX_TX_FILL) begin
            read_byte = {2'h0, tx_fill};
          end else if (idx == IDX_RX_FILL) begin
            read_byte = {2'h0, rx_fill};
          end else if (idx == IDX_EXT_CONTROL) begin
            read_byte = st.ext_control;
          end
        end
        BANK_3: begin
          if (idx == IDX_REVISION) begin
            read_byte = {MODULE_TYPE, REVISION};
          end else if (idx == IDX_LINE_SHADOW) begin
            read_byte = st.line_control;
          end else if (idx == IDX_FIFO_SHADOW) begin
            read_byte = st.fifo_control;
          end
        end
        BANK_4: begin
          unique case (idx)
            IDX_TIMER_LOW: begin
              read_byte = test_mux(test, st.count[7:0],
                                   st.reload[7:0]);
            end
            IDX_TIMER_HIGH: begin
              read_byte = test_mux(test, {4'h0, st.high_latch},
                                   {4'h0, st.reload[11:8]});
            end
            IDX_IR_CONTROL: begin
              read_byte = {4'h0, st.ir_control};
            end
            IDX_TX_LEN_LOW: begin
              read_byte = test_mux(test, tx_cnt[7:0], st.tx_len[7:0]);
            end
            IDX_TX_LEN_HIGH: begin
              read_byte = test_mux(test, frame_hi(tx_cnt),
                                   frame_hi(st.tx_len));
            end
            IDX_RX_LEN_LOW: begin
              read_byte = test_mux(test, rx_cnt[7:0], st.rx_len[7:0]);
            end
            IDX_RX_LEN_HIGH: begin
              read_byte = test_mux(test, frame_hi(rx_cnt),
                                   frame_hi(st.rx_len));
            end
            default: begin
              read_byte = BYTE_RST;
            end
          endcase
        end
        default: begin
          read_byte = BYTE_RST;
        end
      endcase
    end
  endfunction

  // Next state: bus answer, register writes, read side effects and timer.
  always_comb begin
    logic access;
    logic first;
    logic done;
    logic bad;
    logic tick;
    logic [2:0] idx;
    logic [2:0] bank;
    logic [7:0] wbyte;
    access = 1'b0;
    first = 1'b0;
    done = 1'b0;
    bad = 1'b0;
    tick = 1'b0;
    idx = 3'h0;
    bank = 3'h0;
    wbyte = 8'h00;
    st_nxt = st_r;
    st_nxt.expire = 1'b0;

    // Decode the request: the first access cycle forms the answer, the
    // second completes it. Addresses above index 7 are refused.
    access = i_apb.psel & i_apb.penable;
    first = access & ~st_r.apb.pready;
    done = access & st_r.apb.pready;
    idx = i_apb.paddr[4:2];
    bad = |i_apb.paddr[APB_AW-1:5];
    bank = cur_bank(st_r.line_bank);
    wbyte = i_apb.pwdata[7:0];

    // One wait state: the answer and its data are formed in the first access
    // cycle so that every bus output comes from a flip-flop.
    // A refused address still answers, with pslverr and zero data.
    st_nxt.apb.pready = first;
    if (first) begin
      st_nxt.apb.pslverr = bad;
      if (bad || i_apb.pwrite) begin
        st_nxt.apb.prdata = 32'h0000_0000;
      end else begin
        st_nxt.apb.prdata = {24'h00_0000, read_byte(st_r, bank, idx,
          i_tx_fill_count, i_rx_fill_count,
          i_tx_frame_count, i_rx_frame_count)};
      end
    end else if (!access) begin
      st_nxt.apb.pslverr = 1'b0;
    end

    // Interval timer prescaler and down-counter.
    // The prescaler only runs while the timer is enabled, so a stopped timer
    // resumes with a partial tick. A count of zero (never programmed after
    // reset) takes the reload on the first tick and signals expiry.
    if (st_r.ir_control[ICR_RUN_BIT]) begin
      if (st_r.presc >= PRESC_LAST) begin
        st_nxt.presc = '0;
        tick = 1'b1;
      end else begin
        st_nxt.presc = st_r.presc + 1'b1;
      end
    end
    if (tick) begin
      if (st_r.count <= COUNT_ONE) begin
        st_nxt.count = st_r.reload;
        st_nxt.expire = 1'b1;
      end else begin
        st_nxt.count = st_r.count - COUNT_ONE;
      end
    end

    // The high nibble is caught in the same cycle the low byte is sampled,
    // so the pair read back is one coherent counter value.
    // A high read without a low read first returns an old nibble.
    if (first && !bad && !i_apb.pwrite && bank == BANK_4 &&
        idx == IDX_TIMER_LOW) begin
      st_nxt.high_latch = st_r.count[11:8];
    end

    // Writes take effect at the completing edge only.
    // Writes to reserved locations are dropped without an error, as are
    // the reserved upper bits of the timer high byte and of control one.
    // Frame length halves are independent; software writes low first.
    if (done && !bad && i_apb.pwrite) begin
      if (idx == IDX_LINE_BANK) begin
        st_nxt.line_bank = wbyte;
        if (!wbyte[BANK_SEL_BIT]) begin
          st_nxt.line_control = wbyte;
        end
      end else begin
        unique case (bank)
          BANK_0: begin
            if (idx == IDX_FIFO_CONTROL) begin
              st_nxt.fifo_control = wbyte;
            end
          end
          BANK_2: begin
            if (idx == IDX_EXT_CONTROL) begin
              st_nxt.ext_control = wbyte;
            end
          end
          BANK_4: begin
            unique case (idx)
              IDX_TIMER_LOW: begin
                st_nxt.reload[7:0] = wbyte;
              end
              IDX_TIMER_HIGH: begin
                st_nxt.reload[11:8] = wbyte[3:0];
                st_nxt.count = {wbyte[3:0], st_r.reload[7:0]};
                st_nxt.presc = '0;
              end
              IDX_IR_CONTROL: begin
                st_nxt.ir_control = wbyte[3:0];
              end
              IDX_TX_LEN_LOW: begin
                st_nxt.tx_len[7:0] = wbyte;
              end
              IDX_TX_LEN_HIGH: begin
                st_nxt.tx_len[12:8] = wbyte[4:0];
              end
              IDX_RX_LEN_LOW: begin
                st_nxt.rx_len[7:0] = wbyte;
              end
              IDX_RX_LEN_HIGH: begin
                st_nxt.rx_len[12:8] = wbyte[4:0];
              end
              default: begin
                st_nxt.line_bank = st_r.line_bank;
              end
            endcase
          end
          default: begin
            // Banks 1, 3 and 5 to 7, where no location is writable.
            st_nxt.line_bank = st_r.line_bank;
          end
        endcase
      end
    end

    // Legacy select acts only while extended mode is off.
    // Reserved code 01 is passed on as is; the line logic decides.
    if (st_nxt.ext_control[EXT_MODE_BIT]) begin
      st_nxt.if_mode = SIT_IF_SERIAL;
    end else begin
      st_nxt.if_mode = sit_if_mode_e'(
        st_nxt.ir_control[ICR_SEL_LSB +: 2]);
    end

    // Synchronous reset overrides everything else. The timer reload and
    // count are cleared although software must not rely on their value.
    if (i_rst) begin
      st_nxt = SIT_STATE_RST;
    end
  end

  // Single state register; reset is folded in above, so it is synchronous.
  // No clock enable: every field is rewritten on every edge.
  always_ff @(posedge i_core_clk) begin
    st_r <= st_nxt;
  end

  // Outputs come straight from state fields.
  // The bus answer is registered, which costs the one wait state.
  // Control outputs change only at the completing edge of a write.
  assign o_apb = st_r.apb;
  assign o_line_control = st_r.line_control;
  assign o_fifo_control = st_r.fifo_control;
  assign o_extended_mode = st_r.ext_control[EXT_MODE_BIT];
  assign o_legacy_infrared_select = st_r.if_mode;
  assign o_tx_frame_length = st_r.tx_len;
  assign o_rx_frame_max_length = st_r.rx_len;
  assign o_timer_expired = st_r.expire;
  assign o_timer_count = st_r.count;

endmodule

// File: dv/sit_regs_properties.sv
// Port-level assertions for the status, shadow and timer register banks.
module sit_regs_checker
  import sit_pkg::*;
(
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Register bus.
  input wire sit_apb_req_s i_apb,
  input wire sit_apb_rsp_s o_apb,
  // Control outputs and timer.
  input wire logic [7:0] o_line_control,
  input wire logic [7:0] o_fifo_control,
  input wire logic o_extended_mode,
  input wire sit_if_mode_e o_legacy_infrared_select,
  input wire logic [FRAME_W-1:0] o_tx_frame_length,
  input wire logic o_timer_expired,
  input wire logic [TIMER_W-1:0] o_timer_count
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  // A completing write; the control values checked below may only move on one of these.
  logic wr_done;
  assign wr_done = o_apb.pready && i_apb.pwrite;

  a_ready_one_wait: assert property (
    i_apb.psel && $rose(i_apb.penable) |=> o_apb.pready ##1 !o_apb.pready)
    else $error("ready not exactly one wait state after access");
  a_ready_held: assert property (
    o_apb.pready |-> i_apb.psel && i_apb.penable)
    else $error("ready without an access phase");
  a_slverr_addr: assert property (
    o_apb.pready |-> o_apb.pslverr == (i_apb.paddr[7:5] != 3'h0))
    else $error("error flag does not match address range");
  a_expire_pulse: assert property (
    o_timer_expired |=> !o_timer_expired)
    else $error("expiry longer than one cycle");
  a_count_steps: assert property (
    $changed(o_timer_count) && !$past(wr_done) |->
    (o_timer_count == $past(o_timer_count) - 12'h1) or
    (##[0:1] o_timer_expired))
    else $error("counter moved other than by one step or reload");
  a_legacy_ext: assert property (
    o_extended_mode && $past(o_extended_mode) |->
    o_legacy_infrared_select == SIT_IF_SERIAL)
    else $error("legacy select active in extended mode");
  a_line_follow: assert property (
    $changed(o_line_control) |->
    $past(wr_done && i_apb.paddr == 8'h0C && !i_apb.pwdata[7]) &&
    o_line_control == $past(i_apb.pwdata[7:0]))
    else $error("line control changed without its write");
  a_fifo_follow: assert property (
    $changed(o_fifo_control) |->
    $past(wr_done && i_apb.paddr == 8'h08) &&
    o_fifo_control == $past(i_apb.pwdata[7:0]))
    else $error("fifo control changed without its write");
  a_txlen_follow: assert property (
    $changed(o_tx_frame_length) |->
    $past(wr_done && i_apb.paddr inside {8'h10, 8'h14}))
    else $error("frame length changed without its write");
endmodule

// File: dv/sit_regs_tb.sv
// Self-checking bench for the status, shadow and timer register banks.
module sit_regs_tb
  import sit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst = 1'b1;
  sit_apb_req_s req = '0;
  sit_apb_rsp_s rsp;
  logic [FILL_W-1:0] txf = '0, rxf = '0;
  logic [FRAME_W-1:0] txc = '0, rxc = '0, txl, rxl;
  logic [7:0] lc, fc;
  logic ext, exp, er;
  sit_if_mode_e leg;
  logic [TIMER_W-1:0] cnt;
  logic [31:0] q;
  int fails = 0, comparisons = 0, cyc = 0;

  // Short prescale keeps each timer tick at four clocks; identity arbitrary.
  sit_regs #(.MODULE_TYPE(4'hA), .REVISION(4'h3), .TICK_COUNT(4)) dut (
    .i_core_clk(clk), .i_rst(rst), .i_apb(req), .o_apb(rsp),
    .i_tx_fill_count(txf), .i_rx_fill_count(rxf),
    .i_tx_frame_count(txc), .i_rx_frame_count(rxc),
    .o_line_control(lc), .o_fifo_control(fc), .o_extended_mode(ext),
    .o_legacy_infrared_select(leg), .o_tx_frame_length(txl),
    .o_rx_frame_max_length(rxl), .o_timer_expired(exp),
    .o_timer_count(cnt));

  // Clock and a watchdog that cuts a hang short.
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  // One APB transfer; an idle edge first keeps drives one per time step.
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
             pwdata: {24'h0, d}};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n == 20) fails++;
    q = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  // Writes settle to the falling edge so outputs are read after update.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    apb(1'b0, a, 8'h00);
    chk(nm, {24'h0, e}, q);
  endtask
  task automatic bank(input logic [2:0] b);
    wr(8'h0C, {5'h10, b});
  endtask

  task automatic t_reset();
    chk("line", 32'h0, {24'h0, lc});
    chk("lens", {6'h0, 13'h800, 13'h800}, {6'h0, txl, rxl});
    bank(BANK_4);
    rd(8'h08, 8'h00, "ircr rst");
    bank(BANK_2);
    rd(8'h14, 8'h00, "rsvd rst");
  endtask

  task automatic t_bank2();
    logic [31:0] a1, a2;
    txf <= 6'h3F;
    rxf <= 6'h2A;
    wr(8'h14, 8'hFF);
    rd(8'h14, 8'h00, "rsvd wr");
    rd(8'h18, 8'h3F, "txfill");
    apb(1'b0, 8'h1C, 8'h00);
    a1 = q;
    rxf <= 6'h15;
    apb(1'b0, 8'h1C, 8'h00);
    a2 = q;
    apb(1'b0, 8'h1C, 8'h00);
    chk("rxfill", 32'h15, (a1 === a2) ? a2 : q);
    wr(8'h08, 8'h01);
    chk("ext", 32'h1, {31'h0, ext});
  endtask

  task automatic t_ircr();
    bank(BANK_4);
    wr(8'h08, 8'h0C);
    chk("leg ext", 32'h0, {30'h0, leg});
    bank(BANK_2);
    wr(8'h08, 8'h00);
    chk("leg", 32'h3, {30'h0, leg});
    bank(BANK_4);
    for (int s = 0; s < 4; s++) begin
      wr(8'h08, {4'hF, s[1:0], 2'b00});
      rd(8'h08, {4'h0, s[1:0], 2'b00}, "ircr");
      chk("leg", s, {30'h0, leg});
    end
    wr(8'h08, 8'h00);
  endtask

  task automatic t_bank3();
    wr(8'h0C, 8'h1B);
    chk("line", 32'h1B, {24'h0, lc});
    wr(8'h08, 8'hC7);
    chk("fifo", 32'hC7, {24'h0, fc});
    bank(BANK_3);
    rd(8'h00, 8'hA3, "rev");
    rd(8'h04, 8'h1B, "shadow line");
    rd(8'h08, 8'hC7, "shadow fifo");
    rd(8'h0C, 8'h83, "bank reg");
    for (int i = 4; i < 8; i++) rd(8'(i * 4), 8'h00, "rsvd b3");
    wr(8'h0C, 8'h05);
    bank(BANK_3);
    rd(8'h04, 8'h05, "shadow b3");
    apb(1'b0, 8'h20, 8'h00);
    chk("unmapped", 32'h1, {31'h0, er});
  endtask

  task automatic t_timer();
    int n;
    bank(BANK_4);
    wr(8'h00, 8'h05);
    wr(8'h04, 8'h00);
    chk("load", 32'h5, {20'h0, cnt});
    repeat (20) @(posedge clk);
    chk("frozen", 32'h5, {20'h0, cnt});
    rd(8'h00, 8'h05, "live lo");
    wr(8'h08, 8'h01);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (exp !== 1'b1 && n < 100);
    chk("expiry time", 32'h1, {31'h0, n >= 16 && n <= 30});
    chk("reload", 32'h5, {20'h0, cnt});
    wr(8'h08, 8'h00);
    wr(8'h00, 8'h34);
    wr(8'h04, 8'h02);
    rd(8'h00, 8'h34, "lo");
    wr(8'h04, 8'h05);
    rd(8'h04, 8'h02, "latched hi");
    wr(8'h08, 8'h02);
    rd(8'h04, 8'h05, "reload hi");
    rd(8'h00, 8'h34, "reload lo");
  endtask

  task automatic t_frame();
    txc <= 13'h1ABC;
    rxc <= 13'h0777;
    wr(8'h10, 8'h22);
    wr(8'h14, 8'h03);
    wr(8'h18, 8'h44);
    wr(8'h1C, 8'h01);
    chk("lens", {6'h0, 13'h0322, 13'h0144}, {6'h0, txl, rxl});
    rd(8'h10, 8'h22, "txlen lo");
    rd(8'h1C, 8'h01, "rxlen hi");
    wr(8'h08, 8'h00);
    rd(8'h14, 8'h1A, "txcnt hi");
    rd(8'h18, 8'h77, "rxcnt lo");
  endtask

  // Reset for ten cycles, then every scenario in turn.
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_bank2();
    t_ircr();
    t_bank3();
    t_timer();
    t_frame();
    wrap_up();
  end
endmodule

bind sit_regs sit_regs_checker chk_i (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_apb(i_apb), .o_apb(o_apb),
  .o_line_control(o_line_control), .o_fifo_control(o_fifo_control),
  .o_extended_mode(o_extended_mode),
  .o_legacy_infrared_select(o_legacy_infrared_select),
  .o_tx_frame_length(o_tx_frame_length),
  .o_timer_expired(o_timer_expired), .o_timer_count(o_timer_count));
